// [rwpc_pkg.sv]
// constants and types of the reset, wake and power block
`default_nettype none
package rwpc_pkg;
  // ----------------------------------------------------------
  // timing
  // ----------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned MIN_NET_MHZ = 16;
  localparam int unsigned HW_RST_MIN_MS = 100;
  // ----------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------
  localparam logic [7:0] BUS_MODE_OFF = 8'h00;
  localparam logic [7:0] XCVR_CTL_OFF = 8'h04;
  localparam logic [7:0] CFG_WORD_OFF = 8'h08;
  localparam logic [7:0] PWR_STAT_OFF = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h14;
  localparam logic [7:0] IMG_STAT_OFF = 8'h18;
  localparam logic [7:0] ADDR_LO_OFF = 8'h1C;
  localparam logic [7:0] ADDR_HI_OFF = 8'h20;
  localparam logic [7:0] IDS_OFF = 8'h24;
  localparam logic [7:0] SUBSYS_OFF = 8'h28;
  localparam logic [7:0] GRANT_OFF = 8'h2C;
  // ----------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------
  localparam int unsigned SOFT_RST_BIT = 0;
  localparam int unsigned XCVR_RST_BIT = 15;
  localparam int unsigned WAKE_EN_BIT = 18;
  localparam int unsigned WAKE_FLAG_BIT = 15;
  localparam logic [31:0] BUS_MODE_RST = 32'h0000_0000;
  localparam logic [15:0] XCVR_CTL_RST = 16'h1000;
  localparam logic [31:0] CFG_WORD_RST = 32'h0000_0000;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_WAKE = 0;
  localparam int unsigned IRQ_IMG_DONE = 1;
  localparam int unsigned IRQ_IMG_ERR = 2;
  localparam int unsigned IRQ_XCVR = 3;
  // ----------------------------------------------------------
  // configuration image layout
  // ----------------------------------------------------------
  localparam int unsigned IMG_DEPTH = 128;
  localparam logic [6:0] IMG_SIG_OFF = 7'h00;
  localparam logic [6:0] IMG_MAJ_OFF = 7'h02;
  localparam logic [6:0] IMG_MIN_OFF = 7'h03;
  localparam logic [6:0] IMG_ADDR_OFF = 7'h08;
  localparam logic [6:0] IMG_CHK_OFF = 7'h0E;
  localparam logic [6:0] IMG_CONN_OFF = 7'h12;
  localparam logic [6:0] IMG_FLOW_OFF = 7'h1F;
  localparam logic [6:0] IMG_DEV_OFF = 7'h20;
  localparam logic [6:0] IMG_VEN_OFF = 7'h22;
  localparam logic [6:0] IMG_SSID_OFF = 7'h24;
  localparam logic [6:0] IMG_SSVID_OFF = 7'h26;
  localparam logic [6:0] IMG_GNT_OFF = 7'h28;
  localparam logic [6:0] IMG_LAT_OFF = 7'h29;
  localparam logic [6:0] IMG_RECALL_OFF = 7'h2E;
  localparam logic [6:0] IMG_FCS_OFF = 7'h7E;
  localparam logic [6:0] IMG_FCS_LAST = 7'h7D;
  localparam logic [7:0] VER_MAJ = 8'h02;
  localparam logic [7:0] VER_MIN = 8'h00;
  localparam logic [7:0] FLOW_ON = 8'h01;
  localparam logic [15:0] CONN_AUTO = 16'h0100;
  localparam logic [15:0] CONN_100HD = 16'h0003;
  localparam logic [15:0] CONN_100FD = 16'h0013;
  localparam logic [15:0] CONN_DRIVER = 16'hFFFF;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
  // ----------------------------------------------------------
  // wake pattern
  // ----------------------------------------------------------
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [3:0] SYNC_LEN = 4'h6;
  localparam int unsigned ADDR_BYTES = 6;
  localparam logic [2:0] ADDR_LEN = 3'h6;
  localparam logic [4:0] ADDR_REPS = 5'h10;
  // ----------------------------------------------------------
  // types
  // ----------------------------------------------------------
  typedef enum logic [1:0] {PM_D0, PM_D1, PM_D2, PM_D3HOT} dstate_e;
  typedef enum logic {SCAN_SYNC, SCAN_ADDR} scan_e;
  typedef struct packed {
    logic valid;
    logic last;
    logic addr_ok;
    logic crc_ok;
    logic [7:0] data;
  } rx_byte_s;
  typedef struct packed {
    logic valid;
    logic last;
    logic [6:0] addr;
    logic [7:0] data;
  } img_byte_s;
endpackage
`default_nettype wire

// [reset_wake_power_config.sv]
// reset, wake detection and power state logic behind an APB slave
`default_nettype none
// ------------------------------------------------------------
// ------------------------------------------------------------
module reset_wake_power_config #(
  parameter logic [15:0] SIGNATURE = 16'h5AC3 // arbitrary value
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // received bytes from the mac
  input wire rwpc_pkg::rx_byte_s RX,
  // configuration image bytes
  input wire rwpc_pkg::img_byte_s IMG,
  output logic IMG_REQ,
  // chip controls
  output logic SOFT_RST,
  output logic XCVR_RST,
  output logic NET_EN,
  output logic PME_B,
  output logic IRQ
);
  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  logic [31:0] bus_mode_r;
  logic [15:0] xcvr_ctl_r;
  logic [31:0] cfg_word_r;
  rwpc_pkg::dstate_e dstate_r;
  logic pm_rst_r;
  logic wake_flag_r;
  logic [rwpc_pkg::IRQ_W-1:0] irq_stat_r;
  logic [rwpc_pkg::IRQ_W-1:0] irq_mask_r;
  logic [5:0] img_stat_r;
  logic img_eval_r;
  logic [31:0] crc_r;
  logic [7:0] img_mem [rwpc_pkg::IMG_DEPTH];
  rwpc_pkg::scan_e scan_r;
  logic [3:0] ff_cnt_r;
  logic [2:0] byte_k_r;
  logic [4:0] rep_r;
  logic found_r;

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic [7:0] id_sum(input logic [47:0] a);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < rwpc_pkg::ADDR_BYTES; i++) begin
      s = 8'({s[6:0], s[7]} + a[8*i +: 8]);
    end
    return s;
  endfunction

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int b = 0; b < 8; b++) begin
      r = r[0] ? ((r >> 1) ^ rwpc_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ----------------------------------------------------------
  // resets
  // ----------------------------------------------------------
  wire hard_rst = ~RST_B | pm_rst_r;
  wire srst = bus_mode_r[rwpc_pkg::SOFT_RST_BIT];
  wire soft_rst = hard_rst | srst;
  wire in_d0 = (dstate_r == rwpc_pkg::PM_D0);
  localparam logic CLK_OK = (rwpc_pkg::CLK_MHZ >= rwpc_pkg::MIN_NET_MHZ);

  // ----------------------------------------------------------
  // image fields
  // ----------------------------------------------------------
  logic [47:0] sta_w;
  genvar gi;
  generate
    for (gi = 0; gi < rwpc_pkg::ADDR_BYTES; gi++) begin : g_sta
      assign sta_w[8*gi +: 8] =
        img_mem[7'(rwpc_pkg::IMG_ADDR_OFF + 7'(gi))];
    end
  endgenerate

  wire [15:0] sig_w = {img_mem[rwpc_pkg::IMG_SIG_OFF],
                       img_mem[7'(rwpc_pkg::IMG_SIG_OFF + 7'h01)]};
  wire ver_ok = (img_mem[rwpc_pkg::IMG_MAJ_OFF] == rwpc_pkg::VER_MAJ)
              & (img_mem[rwpc_pkg::IMG_MIN_OFF] == rwpc_pkg::VER_MIN);
  wire chk_ok = (id_sum(sta_w) == img_mem[rwpc_pkg::IMG_CHK_OFF]);
  wire [15:0] conn_w = {img_mem[7'(rwpc_pkg::IMG_CONN_OFF + 7'h01)],
                        img_mem[rwpc_pkg::IMG_CONN_OFF]};
  wire flow_en = (img_mem[rwpc_pkg::IMG_FLOW_OFF]
                  == rwpc_pkg::FLOW_ON);
  wire [15:0] dev_w = {img_mem[7'(rwpc_pkg::IMG_DEV_OFF + 7'h01)],
                       img_mem[rwpc_pkg::IMG_DEV_OFF]};
  wire [15:0] ven_w = {img_mem[7'(rwpc_pkg::IMG_VEN_OFF + 7'h01)],
                       img_mem[rwpc_pkg::IMG_VEN_OFF]};
  wire [15:0] ssid_w = {img_mem[7'(rwpc_pkg::IMG_SSID_OFF + 7'h01)],
                        img_mem[rwpc_pkg::IMG_SSID_OFF]};
  wire [15:0] ssvid_w = {img_mem[7'(rwpc_pkg::IMG_SSVID_OFF + 7'h01)],
                         img_mem[rwpc_pkg::IMG_SSVID_OFF]};
  wire [7:0] gnt_w = img_mem[rwpc_pkg::IMG_GNT_OFF];
  wire [7:0] lat_w = img_mem[rwpc_pkg::IMG_LAT_OFF];
  wire [15:0] recall_w = {img_mem[7'(rwpc_pkg::IMG_RECALL_OFF + 7'h01)],
                          img_mem[rwpc_pkg::IMG_RECALL_OFF]};
  wire [15:0] fcs_w = {img_mem[7'(rwpc_pkg::IMG_FCS_OFF + 7'h01)],
                       img_mem[rwpc_pkg::IMG_FCS_OFF]};
  wire fcs_ok = (fcs_w == ~crc_r[15:0]);
  wire sig_ok = (sig_w == SIGNATURE);
  wire img_good = sig_ok & ver_ok & chk_ok & fcs_ok;

  // ----------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------
  wire acc = PSEL & PENABLE;
  wire first = acc & ~PREADY;
  wire wr_go = acc & PREADY & PWRITE & ~PSLVERR;
  wire hit_bm = (PADDR == rwpc_pkg::BUS_MODE_OFF);
  wire hit_xc = (PADDR == rwpc_pkg::XCVR_CTL_OFF);
  wire hit_cw = (PADDR == rwpc_pkg::CFG_WORD_OFF);
  wire hit_pw = (PADDR == rwpc_pkg::PWR_STAT_OFF);
  wire hit_is = (PADDR == rwpc_pkg::IRQ_STAT_OFF);
  wire hit_im = (PADDR == rwpc_pkg::IRQ_MASK_OFF);
  wire hit_st = (PADDR == rwpc_pkg::IMG_STAT_OFF);
  wire hit_al = (PADDR == rwpc_pkg::ADDR_LO_OFF);
  wire hit_ah = (PADDR == rwpc_pkg::ADDR_HI_OFF);
  wire hit_id = (PADDR == rwpc_pkg::IDS_OFF);
  wire hit_ss = (PADDR == rwpc_pkg::SUBSYS_OFF);
  wire hit_gr = (PADDR == rwpc_pkg::GRANT_OFF);
  wire cfg_space = hit_cw | hit_pw | hit_id | hit_ss | hit_gr;
  wire mapped = cfg_space | hit_bm | hit_xc | hit_is | hit_im
              | hit_st | hit_al | hit_ah;
  wire allowed = mapped & (in_d0 | cfg_space);
  wire we_bm = wr_go & hit_bm;
  wire we_xc = wr_go & hit_xc;
  wire we_cw = wr_go & hit_cw;
  wire we_pw = wr_go & hit_pw;
  wire we_is = wr_go & hit_is;
  wire we_im = wr_go & hit_im;

  wire [31:0] pw_val = {16'h0000, wake_flag_r, 13'h0000, dstate_r};
  wire [31:0] rd_mux =
      ({32{hit_bm}} & bus_mode_r)
    | ({32{hit_xc}} & {16'h0000, xcvr_ctl_r})
    | ({32{hit_cw}} & cfg_word_r)
    | ({32{hit_pw}} & pw_val)
    | ({32{hit_is}} & {28'h0000000, irq_stat_r})
    | ({32{hit_im}} & {28'h0000000, irq_mask_r})
    | ({32{hit_st}} & {26'h0, img_stat_r})
    | ({32{hit_al}} & sta_w[31:0])
    | ({32{hit_ah}} & {conn_w, sta_w[47:32]})
    | ({32{hit_id}} & {dev_w, ven_w})
    | ({32{hit_ss}} & {ssid_w, ssvid_w})
    | ({32{hit_gr}} & {8'h00, img_mem[rwpc_pkg::IMG_FLOW_OFF],
                       lat_w, gnt_w});

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= first;
      PSLVERR <= first & ~allowed;
      PRDATA <= (first & allowed & ~PWRITE) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------
  // control registers
  // ----------------------------------------------------------
  wire pm_rst_nxt = we_pw & (dstate_r == rwpc_pkg::PM_D3HOT)
                  & (PWDATA[1:0] == rwpc_pkg::PM_D0);

  always_ff @(posedge CLOCK) begin
    if (soft_rst) begin
      bus_mode_r <= rwpc_pkg::BUS_MODE_RST;
    end else if (we_bm) begin
      bus_mode_r <= PWDATA;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (hard_rst || xcvr_ctl_r[rwpc_pkg::XCVR_RST_BIT]) begin
      xcvr_ctl_r <= rwpc_pkg::XCVR_CTL_RST;
    end else if (we_xc) begin
      xcvr_ctl_r <= PWDATA[15:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (hard_rst) begin
      cfg_word_r <= rwpc_pkg::CFG_WORD_RST;
    end else if (we_cw) begin
      cfg_word_r <= PWDATA;
    end else if (img_eval_r) begin
      cfg_word_r <= {recall_w, cfg_word_r[15:0]};
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      pm_rst_r <= 1'b0;
    end else begin
      pm_rst_r <= pm_rst_nxt;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (hard_rst) begin
      dstate_r <= rwpc_pkg::PM_D0;
    end else if (we_pw && !pm_rst_nxt) begin
      dstate_r <= rwpc_pkg::dstate_e'(PWDATA[1:0]);
    end
  end

  // ----------------------------------------------------------
  // configuration image capture
  // ----------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (hard_rst) begin
      for (int i = 0; i < rwpc_pkg::IMG_DEPTH; i++) begin
        img_mem[i] <= 8'h00;
      end
    end else if (IMG.valid) begin
      img_mem[IMG.addr] <= IMG.data;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (hard_rst) begin
      crc_r <= rwpc_pkg::CRC_INIT;
    end else if (IMG.valid && IMG.addr <= rwpc_pkg::IMG_FCS_LAST) begin
      crc_r <= crc_byte((IMG.addr == 7'h00) ? rwpc_pkg::CRC_INIT
                        : crc_r, IMG.data);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (hard_rst) begin
      img_eval_r <= 1'b0;
      img_stat_r <= 6'h00;
      IMG_REQ <= 1'b1;
    end else begin
      img_eval_r <= IMG.valid & IMG.last;
      if (img_eval_r) begin
        img_stat_r <= {1'b1, flow_en, fcs_ok, chk_ok, ver_ok, sig_ok};
      end
      if (IMG.valid && IMG.last) begin
        IMG_REQ <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // wake pattern scanner
  // ----------------------------------------------------------
  rwpc_pkg::scan_e scan_nxt;
  logic [3:0] ff_cnt_nxt;
  logic [2:0] byte_k_nxt;
  logic [4:0] rep_nxt;
  logic found_nxt;
  wire [7:0] sta_byte = img_mem[7'(rwpc_pkg::IMG_ADDR_OFF
                                   + {4'h0, byte_k_r})];
  wire is_sync = (RX.data == rwpc_pkg::SYNC_BYTE);

  always_comb begin
    scan_nxt = scan_r;
    ff_cnt_nxt = ff_cnt_r;
    byte_k_nxt = byte_k_r;
    rep_nxt = rep_r;
    found_nxt = found_r;
    if (RX.valid) begin
      case (scan_r)
        rwpc_pkg::SCAN_SYNC: begin
          if (!is_sync) begin
            ff_cnt_nxt = 4'h0;
          end else if (4'(ff_cnt_r + 4'h1) == rwpc_pkg::SYNC_LEN) begin
            scan_nxt = rwpc_pkg::SCAN_ADDR;
            byte_k_nxt = 3'h0;
            rep_nxt = 5'h00;
          end else begin
            ff_cnt_nxt = 4'(ff_cnt_r + 4'h1);
          end
        end
        rwpc_pkg::SCAN_ADDR: begin
          if (RX.data == sta_byte) begin
            if (3'(byte_k_r + 3'h1) == rwpc_pkg::ADDR_LEN) begin
              byte_k_nxt = 3'h0;
              if (5'(rep_r + 5'h01) == rwpc_pkg::ADDR_REPS) begin
                found_nxt = 1'b1;
                scan_nxt = rwpc_pkg::SCAN_SYNC;
                ff_cnt_nxt = 4'h0;
              end else begin
                rep_nxt = 5'(rep_r + 5'h01);
              end
            end else begin
              byte_k_nxt = 3'(byte_k_r + 3'h1);
            end
          end else if (!(is_sync && byte_k_r == 3'h0
                         && rep_r == 5'h00)) begin
            scan_nxt = rwpc_pkg::SCAN_SYNC;
            ff_cnt_nxt = is_sync ? 4'h1 : 4'h0;
          end
        end
        default: begin
          scan_nxt = rwpc_pkg::SCAN_SYNC;
          ff_cnt_nxt = 4'h0;
        end
      endcase
      if (RX.last) begin
        scan_nxt = rwpc_pkg::SCAN_SYNC;
        ff_cnt_nxt = 4'h0;
        found_nxt = 1'b0;
      end
    end
  end

  wire wake_hit = RX.valid & RX.last & RX.addr_ok & RX.crc_ok
                & (found_r | (found_nxt & ~RX.last))
                & cfg_word_r[rwpc_pkg::WAKE_EN_BIT];

  always_ff @(posedge CLOCK) begin
    if (soft_rst) begin
      scan_r <= rwpc_pkg::SCAN_SYNC;
      ff_cnt_r <= 4'h0;
      byte_k_r <= 3'h0;
      rep_r <= 5'h00;
      found_r <= 1'b0;
    end else begin
      scan_r <= scan_nxt;
      ff_cnt_r <= ff_cnt_nxt;
      byte_k_r <= byte_k_nxt;
      rep_r <= rep_nxt;
      found_r <= found_nxt;
    end
  end

  // ----------------------------------------------------------
  // wake flag and interrupts
  // ----------------------------------------------------------
  wire wake_clr = we_pw & PWDATA[rwpc_pkg::WAKE_FLAG_BIT];
  logic [rwpc_pkg::IRQ_W-1:0] irq_evt;
  assign irq_evt[rwpc_pkg::IRQ_WAKE] = wake_hit;
  assign irq_evt[rwpc_pkg::IRQ_IMG_DONE] = img_eval_r;
  assign irq_evt[rwpc_pkg::IRQ_IMG_ERR] = img_eval_r & ~img_good;
  assign irq_evt[rwpc_pkg::IRQ_XCVR] =
    xcvr_ctl_r[rwpc_pkg::XCVR_RST_BIT];

  always_ff @(posedge CLOCK) begin
    if (hard_rst) begin
      wake_flag_r <= 1'b0;
    end else begin
      wake_flag_r <= wake_hit | (wake_flag_r & ~wake_clr);
    end
  end

  always_ff @(posedge CLOCK) begin
    if (soft_rst) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= irq_evt
                  | (irq_stat_r & ~({rwpc_pkg::IRQ_W{we_is}}
                  & PWDATA[rwpc_pkg::IRQ_W-1:0]));
      if (we_im) begin
        irq_mask_r <= PWDATA[rwpc_pkg::IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign SOFT_RST = bus_mode_r[rwpc_pkg::SOFT_RST_BIT];
  assign XCVR_RST = xcvr_ctl_r[rwpc_pkg::XCVR_RST_BIT];

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      NET_EN <= 1'b0;
      PME_B <= 1'b1;
      IRQ <= 1'b0;
    end else begin
      NET_EN <= ~soft_rst & in_d0 & CLK_OK;
      PME_B <= ~wake_flag_r;
      IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  soft_clear_a: assert property (srst |=> !srst)
    else $error("soft reset bit did not self-clear");
  xcvr_clear_a: assert property (
    XCVR_RST |=> xcvr_ctl_r == rwpc_pkg::XCVR_CTL_RST)
    else $error("transceiver register not restored");
  wake_gate_a: assert property (
    $rose(wake_flag_r) |-> $past(cfg_word_r[rwpc_pkg::WAKE_EN_BIT]))
    else $error("wake flag set while wake disabled");
  wake_qual_a: assert property (
    $rose(wake_flag_r) |-> $past(RX.crc_ok & RX.addr_ok & RX.last))
    else $error("wake flag set by unqualified frame");
  pme_follow_a: assert property (
    wake_flag_r && !pm_rst_r |=> !PME_B)
    else $error("wake output not asserted");
  wake_hold_a: assert property (
    wake_flag_r && !wake_clr && !pm_rst_r |=> wake_flag_r [*1])
    else $error("wake flag dropped without clear");
  net_off_a: assert property (
    !in_d0 |=> !NET_EN)
    else $error("network enabled outside D0");
  cfg_only_a: assert property (
    first && !in_d0 && !cfg_space |=> PREADY && PSLVERR)
    else $error("low power state answered non-config access");
  pm_reset_a: assert property (
    pm_rst_r |=> dstate_r == rwpc_pkg::PM_D0 && IMG_REQ
      && cfg_word_r == rwpc_pkg::CFG_WORD_RST)
    else $error("D3hot exit did not reset");
  word_recall_a: assert property (
    img_eval_r && !we_cw |=> cfg_word_r[31:16] == $past(recall_w))
    else $error("config word upper half not recalled");
endmodule
`default_nettype wire

// [rwpc_img_model.sv]
// configuration image memory that streams into the block
`default_nettype none
module rwpc_img_model #(
  parameter logic [47:0] MAC = 48'h0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // image stream
  input wire logic req,
  output var rwpc_pkg::img_byte_s img
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [128];
  logic [7:0] s;
  logic [31:0] crc;
  logic [6:0] idx;
  logic done;
  // ----------------------------------------
  // image contents
  // ----------------------------------------
  initial begin
    mem = '{default: 8'h00};
    mem[0] = 8'h5A;
    mem[1] = 8'hC3;
    mem[2] = rwpc_pkg::VER_MAJ;
    s = 8'h00;
    for (int i = 0; i < 6; i++) begin
      mem[8 + i] = MAC[8*i +: 8];
      s = {s[6:0], 1'b0} + {7'h00, s[7]} + mem[8 + i];
    end
    mem[14] = s;
    mem[7'h12] = 8'h13;
    mem[7'h1F] = 8'h01;
    mem[7'h28] = 8'h11;
    mem[7'h29] = 8'h22;
    mem[7'h2E] = 8'h04;
    crc = 32'hFFFF_FFFF;
    for (int i = 0; i < 126; i++) begin
      crc = crc ^ {24'h000000, mem[i]};
      for (int k = 0; k < 8; k++) begin
        crc = crc[0] ? (crc >> 1) ^ 32'hEDB8_8320 : crc >> 1;
      end
    end
    mem[126] = ~crc[7:0];
    mem[127] = ~crc[15:8];
  end
  // ----------------------------------------
  // byte stream, bus toggles when idle
  // ----------------------------------------
  always @(posedge clk) begin
    if (!rst_b || !req) begin
      idx <= 7'h00;
      done <= 1'b0;
    end else if (!done) begin
      idx <= idx + 7'h01;
      done <= idx == 7'h7F;
    end
    if (!rst_b) begin
      img <= '0;
    end else if (req && !done) begin
      img <= '{1'b1, idx == 7'h7F, idx, mem[idx]};
    end else begin
      img <= '{1'b0, 1'b0, 7'h00, ~img.data};
    end
  end
endmodule
`default_nettype wire

// [reset_wake_power_config_tb.sv]
// self-checking bench of the reset, wake and power block
`default_nettype none
module reset_wake_power_config_tb;
  timeunit 1ns;
  timeprecision 1ns;
  function automatic logic [7:0] lf(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [47:0] mk_mac();
    logic [7:0] s;
    logic [47:0] m;
    s = 8'h19;
    for (int i = 0; i < 6; i++) begin
      s = lf(s);
      m[8*i +: 8] = s;
    end
    return m;
  endfunction
  localparam logic [47:0] MAC = mk_mac();
  logic CLOCK = 1'b0;
  logic RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
  logic IMG_REQ, NET_EN, PME_B, IRQ, SOFT_RST, XCVR_RST;
  logic [7:0] PADDR;
  logic [7:0] rnd = 8'h19;
  logic [31:0] PWDATA, PRDATA, rd;
  rwpc_pkg::rx_byte_s RX;
  rwpc_pkg::img_byte_s IMG;
  int n_mismatch = 0;
  int n_compared = 0;
  always #5 CLOCK = ~CLOCK;
  int n_pulse = 0;
  always @(negedge CLOCK) if (SOFT_RST || XCVR_RST) n_pulse++;
  reset_wake_power_config u_reset_wake_power_config (.CLOCK(CLOCK),
    .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RX(RX), .IMG(IMG), .IMG_REQ(IMG_REQ),
    .SOFT_RST(SOFT_RST), .XCVR_RST(XCVR_RST), .NET_EN(NET_EN),
    .PME_B(PME_B), .IRQ(IRQ));
  rwpc_img_model #(.MAC(MAC)) u_rwpc_img_model (.clk(CLOCK),
    .rst_b(RST_B), .req(IMG_REQ), .img(IMG));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, er}, {31'h0, ee});
  endtask
  task put(input logic [7:0] b, input logic l, input logic ok);
    RX <= '{1'b1, l, 1'b1, ok, b};
    @(posedge CLOCK);
  endtask
  task frame(input logic ok, input int reps);
    rnd = lf(rnd);
    put(rnd, 1'b0, 1'b0);
    for (int k = 0; k < reps; k++) begin
      for (int i = 0; i < 7; i++) put(8'hFF, 1'b0, 1'b0);
      for (int i = 0; i < 96; i++) put(MAC[8*(i%6) +: 8], 1'b0, 1'b0);
    end
    put(8'h00, 1'b1, ok);
    RX <= {4'h0, ~rnd};
    repeat (4) @(posedge CLOCK);
  endtask
  task wimg;
    while (IMG_REQ !== 1'b0) begin
      @(posedge CLOCK);
    end
    repeat (2) @(posedge CLOCK);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge CLOCK);
    n_mismatch++;
    final_report;
  end
  initial begin
    {RST_B, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    RX = '0;
    repeat (8) @(posedge CLOCK);
    RST_B <= 1'b1;
    wimg();
    rdc(rwpc_pkg::IMG_STAT_OFF, 32'h3F, 1'b0);
    rdc(rwpc_pkg::CFG_WORD_OFF, 32'h0004_0000, 1'b0);
    rdc(rwpc_pkg::ADDR_LO_OFF, MAC[31:0], 1'b0);
    rdc(rwpc_pkg::ADDR_HI_OFF, {16'h0013, MAC[47:32]}, 1'b0);
    rdc(rwpc_pkg::GRANT_OFF, 32'h0001_2211, 1'b0);
    apb(1'b1, rwpc_pkg::IRQ_MASK_OFF, 32'h1);
    frame(1'b0, 1);
    chk(PME_B, 1'b1);
    frame(1'b1, 2);
    chk(PME_B, 1'b0);
    chk(IRQ, 1'b1);
    rdc(rwpc_pkg::PWR_STAT_OFF, 32'h8000, 1'b0);
    chk(PME_B, 1'b0);
    apb(1'b1, rwpc_pkg::PWR_STAT_OFF, 32'h8000);
    apb(1'b1, rwpc_pkg::IRQ_STAT_OFF, 32'h1);
    @(posedge CLOCK);
    chk({PME_B, IRQ}, 2'b10);
    apb(1'b1, rwpc_pkg::CFG_WORD_OFF, 32'h0);
    frame(1'b1, 1);
    chk(PME_B, 1'b1);
    apb(1'b1, rwpc_pkg::XCVR_CTL_OFF, 32'h8000);
    rdc(rwpc_pkg::XCVR_CTL_OFF, 32'h1000, 1'b0);
    chk(n_pulse, 32'h1);
    rdc(rwpc_pkg::IRQ_STAT_OFF, 32'hA, 1'b0);
    apb(1'b1, rwpc_pkg::BUS_MODE_OFF, 32'h1);
    rdc(rwpc_pkg::BUS_MODE_OFF, 32'h0, 1'b0);
    chk(n_pulse, 32'h2);
    rdc(rwpc_pkg::IRQ_MASK_OFF, 32'h0, 1'b0);
    rdc(8'h40, 32'h0, 1'b1);
    apb(1'b1, rwpc_pkg::PWR_STAT_OFF, 32'h3);
    rdc(rwpc_pkg::BUS_MODE_OFF, 32'h0, 1'b1);
    chk(NET_EN, 1'b0);
    rdc(rwpc_pkg::PWR_STAT_OFF, 32'h3, 1'b0);
    apb(1'b1, rwpc_pkg::PWR_STAT_OFF, 32'h0);
    repeat (2) @(posedge CLOCK);
    chk(IMG_REQ, 1'b1);
    wimg();
    rdc(rwpc_pkg::CFG_WORD_OFF, 32'h0004_0000, 1'b0);
    apb(1'b1, rwpc_pkg::PWR_STAT_OFF, 32'h2);
    RST_B <= 1'b0;
    repeat (8) @(posedge CLOCK);
    RST_B <= 1'b1;
    wimg();
    rdc(rwpc_pkg::PWR_STAT_OFF, 32'h0, 1'b0);
    chk(NET_EN, 1'b1);
    rdc(rwpc_pkg::CFG_WORD_OFF, 32'h0004_0000, 1'b0);
    final_report;
  end
endmodule
`default_nettype wire
